// ===== src/cidfsk_regs.sv
// Caller-ID FSK sequencer and line control register bank.
// Assumes command bytes arrive one per cycle on a strobe, channel mask given beside.
//
// Function
// - Data byte count valid 0..64, larger clamps to 64, zero sends none.
// - Seizure sends 2*field '01' pairs, up to 510, none when zero.
// - Mark phase sends programmed count of one bits, none when zero.
// - Two-bit channel select routes FSK to channel 1..4, channel 1 at reset.
// - FSK function disabled while enable bit is 0, its reset value.
// - Standard bit picks Bell 202 when 0 and V.23 when 1.
// - Trailing mark bit 0 mutes output after the data is sent.
// - Trailing mark bit 1 keeps sending ones until the host clears it.
// - Writing go starts sending; it self-clears after the last byte, or after seizure or mark when the data count is 0.
// - All lengths zero make go return to 0 immediately.
// - Polarity bit makes all interrupts active low at 0, high at 1.
// - Processor-mode status read gives hook on even, ground key on odd bits.
// - Status read clears a pending hook or ground-key interrupt.
// - Circuit-mode status reads zero; status goes via command channel only.
// - Any write to the status address clears all pending interrupts.
// - Transmit slot register: 7-bit slot and highway select bit.
// - Reset slots are 0,1,2,3 for channels 1..4 on highway one.
// - Receive slot register: 7-bit slot and highway select bit.
// - Two digital loopback enables per channel, reset disabled.
// - Three analog loopback enables per channel, reset disabled.
// - Rx_path_disconnect bit 1 disconnects the channel's PCM receive path.
// - Flag run of programmed ones sits between consecutive data bytes.
`timescale 1ns/10ps
module cidfsk_regs
  import cidfsk_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  // Command port
  input  wire logic            cmd_valid,
  input  wire logic [7:0]      cmd_byte,
  input  wire logic [7:0]      cmd_wdata,
  input  wire logic [NCH-1:0]  cmd_chan_mask,
  input  wire logic [1:0]      cmd_chan_sel,
  output logic                 rd_valid,
  output logic      [7:0]      rd_data,
  // Mode and line events
  input  wire logic            circuit_control_port,
  input  wire logic [NCH-1:0]  offhook_flags,
  input  wire logic [NCH-1:0]  ground_key_flags,
  input  wire logic            hook_event,
  output logic                 irq_out,
  output logic                 cmd_channel_irq_a,
  output logic                 cmd_channel_irq_b,
  // FSK message data, one byte per entry
  input  wire logic            msg_valid,
  output logic                 msg_ready,
  input  wire logic [7:0]      msg_data,
  // FSK bit stream to the modulator
  output cidfsk_bit_s          fsk_bit,
  input  wire logic            bit_tick,
  // Per-channel line control
  output logic [NCH*8-1:0]     tx_slot_out,
  output logic [NCH*8-1:0]     rx_slot_out,
  output logic [NCH*8-1:0]     loop_out
);

  logic             is_wr;
  logic [6:0]       addr;
  logic [7:0]       data_len;
  logic [7:0]       seize_len;
  logic [7:0]       mark_len;
  logic [7:0]       flag_len;
  cidfsk_ctrl_s     ctrl;
  logic             irq_pol;
  logic             irq_pend;
  logic [7:0]       tx_slot [NCH];
  logic [7:0]       rx_slot [NCH];
  logic [7:0]       loopb   [NCH];
  cidfsk_state_e    state;
  cidfsk_state_e    next_state;
  logic [9:0]       cnt;
  logic [6:0]       bytes_left;
  logic [2:0]       bit_idx;
  logic             done;
  logic             fifo_valid;
  logic [7:0]       fifo_data;
  logic             fifo_pop;
  logic [7:0]       eff_len;
  logic [7:0]       status_byte;

  assign is_wr = cmd_byte[CMD_WRITE_BIT];
  assign addr  = cmd_byte[6:0];
  assign eff_len = (data_len > DATA_MAX) ? DATA_MAX : data_len;

  // Message bytes queue here so the host can preload ahead of the bit pace.
  cidfsk_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (msg_valid),
    .in_ready  (msg_ready),
    .in_data   (msg_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_len  <= RESET_ZERO;
      seize_len <= RESET_ZERO;
      mark_len  <= RESET_ZERO;
      flag_len  <= RESET_ZERO;
      irq_pol   <= 1'b0;
    end else if (cmd_valid && is_wr) begin
      case (addr)
        ADDR_DATA_LEN:  data_len  <= cmd_wdata;
        ADDR_SEIZE_LEN: seize_len <= cmd_wdata;
        ADDR_MARK_LEN:  mark_len  <= cmd_wdata;
        ADDR_FLAG_LEN:  flag_len  <= cmd_wdata;
        ADDR_IRQ_POL:   irq_pol   <= cmd_wdata[IRQPOL_BIT];
        default: ;
      endcase
    end
  end

  // Control register; go self-clears when the sequencer finishes.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl <= '0;
    end else if (cmd_valid && is_wr && addr == ADDR_FSK_CTRL) begin
      ctrl.fsk_channel_select   <= cmd_wdata[CTRL_CS_LO +: 2];
      ctrl.fsk_block_enable     <= cmd_wdata[CTRL_EN];
      ctrl.fsk_standard_select  <= cmd_wdata[CTRL_STD];
      ctrl.trailing_mark_enable <= cmd_wdata[CTRL_TRAIL];
      ctrl.go                   <= cmd_wdata[CTRL_GO];
    end else if (done) begin
      ctrl.go <= 1'b0;
    end
  end

  // Sequencer walks seizure, mark, data, flags, trailing mark.
  always_comb begin
    next_state = state;
    case (state)
      CIDFSK_IDLE: begin
        // Leave idle only on a tick, so the first bit stands a whole bit period.
        if (ctrl.go && ctrl.fsk_block_enable && bit_tick) begin
          if (seize_len != '0) next_state = CIDFSK_SEIZE;
          else if (mark_len != '0) next_state = CIDFSK_MARK;
          else if (eff_len != '0) next_state = CIDFSK_DATA;
          else next_state = CIDFSK_IDLE;
        end
      end
      CIDFSK_SEIZE: begin
        if (bit_tick && cnt == 10'd1) begin
          if (mark_len != '0) next_state = CIDFSK_MARK;
          else if (eff_len != '0) next_state = CIDFSK_DATA;
          else next_state = ctrl.trailing_mark_enable ? CIDFSK_TRAIL : CIDFSK_IDLE;
        end
      end
      CIDFSK_MARK: begin
        if (bit_tick && cnt == 10'd1) begin
          if (eff_len != '0) next_state = CIDFSK_DATA;
          else next_state = ctrl.trailing_mark_enable ? CIDFSK_TRAIL : CIDFSK_IDLE;
        end
      end
      CIDFSK_DATA: begin
        if (bit_tick && bit_idx == 3'd7) begin
          if (bytes_left == 7'd1) begin
            next_state = ctrl.trailing_mark_enable ? CIDFSK_TRAIL : CIDFSK_IDLE;
          end else if (flag_len != '0) begin
            next_state = CIDFSK_FLAG;
          end
        end
      end
      CIDFSK_FLAG: begin
        if (bit_tick && cnt == 10'd1) next_state = CIDFSK_DATA;
      end
      CIDFSK_TRAIL: begin
        if (!ctrl.trailing_mark_enable) next_state = CIDFSK_IDLE;
      end
      default: next_state = CIDFSK_IDLE;
    endcase
    if (!ctrl.fsk_block_enable) next_state = CIDFSK_IDLE;
  end

  // Go clears as the last seizure, mark or data bit ends, or at once when seizure, mark and data counts are all zero.
  assign done = ctrl.go && ((state != CIDFSK_IDLE && state != CIDFSK_TRAIL
                && next_state inside {CIDFSK_IDLE, CIDFSK_TRAIL})
                || (state == CIDFSK_IDLE && seize_len == '0 && mark_len == '0
                && eff_len == '0));
  assign fifo_pop = state == CIDFSK_DATA && bit_tick && bit_idx == 3'd7 && fifo_valid;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state      <= CIDFSK_IDLE;
      cnt        <= '0;
      bit_idx    <= '0;
      bytes_left <= '0;
    end else begin
      state <= next_state;
      if (state == CIDFSK_IDLE) begin
        bytes_left <= eff_len[6:0];
        bit_idx    <= '0;
        // Twice the field in '01' pairs, so four bits per count.
        cnt        <= (seize_len != '0) ? {seize_len, 2'b00} : {2'b00, mark_len};
      end else if (bit_tick) begin
        if (state == CIDFSK_DATA) begin
          bit_idx <= bit_idx + 3'd1;
          if (bit_idx == 3'd7) begin
            bytes_left <= bytes_left - 7'd1;
            cnt        <= {2'b00, flag_len};
          end
        end else if (state == CIDFSK_SEIZE && cnt == 10'd1) begin
          cnt <= {2'b00, mark_len};
        end else if (cnt != '0) begin
          cnt <= cnt - 10'd1;
        end
      end
    end
  end

  // Bit stream; seizure alternates 0 then 1, data sends byte bits LSB first, mark, flags and trailing mark send ones.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fsk_bit <= '0;
    end else begin
      fsk_bit.standard  <= ctrl.fsk_standard_select;
      fsk_bit.channel   <= ctrl.fsk_channel_select;
      fsk_bit.valid     <= state != CIDFSK_IDLE;
      case (state)
        CIDFSK_SEIZE: fsk_bit.bit_value <= cnt[0];
        CIDFSK_DATA:  fsk_bit.bit_value <= fifo_valid ? fifo_data[bit_idx] : 1'b1;
        CIDFSK_IDLE:  fsk_bit.bit_value <= 1'b0;
        default:      fsk_bit.bit_value <= 1'b1;
      endcase
    end
  end

  // Hook event stays pending until status is read or written; a new event wins.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_pend <= 1'b0;
    end else if (hook_event) begin
      irq_pend <= 1'b1;
    end else if (cmd_valid && addr == ADDR_STATUS) begin
      irq_pend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_out           <= 1'b1;
      cmd_channel_irq_a <= 1'b1;
      cmd_channel_irq_b <= 1'b1;
    end else begin
      irq_out           <= irq_pend ~^ irq_pol;
      cmd_channel_irq_a <= irq_pend ~^ irq_pol;
      cmd_channel_irq_b <= irq_pend ~^ irq_pol;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign status_byte[2*g]   = offhook_flags[g];
      assign status_byte[2*g+1] = ground_key_flags[g];
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          tx_slot[g] <= 8'(g);
          rx_slot[g] <= 8'(g);
          loopb[g]   <= RESET_ZERO;
        end else if (cmd_valid && is_wr && cmd_chan_mask[g]) begin
          if (addr == ADDR_TX_SLOT && !circuit_control_port) tx_slot[g] <= cmd_wdata;
          if (addr == ADDR_RX_SLOT && !circuit_control_port) rx_slot[g] <= cmd_wdata;
          if (addr == ADDR_LOOP) begin
            loopb[g] <= circuit_control_port
                      ? (cmd_wdata & LB_MASK & ~(8'h01 << LB_APCM) & ~(8'h01 << LB_DPCM))
                      : (cmd_wdata & LB_MASK);
          end
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          tx_slot_out[g*8 +: 8] <= 8'(g);
          rx_slot_out[g*8 +: 8] <= 8'(g);
          loop_out[g*8 +: 8]    <= RESET_ZERO;
        end else begin
          tx_slot_out[g*8 +: 8] <= tx_slot[g];
          rx_slot_out[g*8 +: 8] <= rx_slot[g];
          loop_out[g*8 +: 8]    <= loopb[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_data  <= RESET_ZERO;
    end else begin
      rd_valid <= cmd_valid && !is_wr;
      case (addr)
        ADDR_DATA_LEN:  rd_data <= data_len;
        ADDR_SEIZE_LEN: rd_data <= seize_len;
        ADDR_MARK_LEN:  rd_data <= mark_len;
        ADDR_FLAG_LEN:  rd_data <= flag_len;
        ADDR_FSK_CTRL:  rd_data <= {2'b00, ctrl.fsk_channel_select, ctrl.fsk_block_enable,
                                    ctrl.fsk_standard_select, ctrl.trailing_mark_enable,
                                    ctrl.go};
        ADDR_IRQ_POL:   rd_data <= {3'b000, irq_pol, 4'h0};
        ADDR_STATUS:    rd_data <= circuit_control_port ? RESET_ZERO : status_byte;
        ADDR_TX_SLOT:   rd_data <= tx_slot[cmd_chan_sel];
        ADDR_RX_SLOT:   rd_data <= rx_slot[cmd_chan_sel];
        ADDR_LOOP:      rd_data <= loopb[cmd_chan_sel];
        default:        rd_data <= RESET_ZERO;
      endcase
    end
  end

  a_circuit_slot_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    cmd_valid && is_wr && circuit_control_port |=> $stable(tx_slot[0]) && $stable(rx_slot[0]))
    else $error("slot written in circuit mode");
  a_go_clears_empty: assert property (@(posedge ref_clk) disable iff (!resetn)
    ctrl.go && state == CIDFSK_IDLE && seize_len == '0 && mark_len == '0 && data_len == '0
    && !(cmd_valid && is_wr) |=> !ctrl.go) else $error("go stuck");
  a_irq_pol: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(irq_pend) && $past(irq_pol) |-> irq_out) else $error("irq polarity wrong");
  a_status_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    cmd_valid && addr == ADDR_STATUS && !hook_event |=> !irq_pend)
    else $error("status access did not clear");
  a_gci_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    cmd_valid && !is_wr && addr == ADDR_STATUS && circuit_control_port |=> rd_data == 8'h00)
    else $error("status not zero in circuit mode");
  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ctrl.fsk_block_enable |=> state == CIDFSK_IDLE) else $error("FSK ran disabled");
  a_mute: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == CIDFSK_IDLE |=> !fsk_bit.valid) else $error("output not muted");
  a_clamp: assert property (@(posedge ref_clk) disable iff (!resetn)
    eff_len <= DATA_MAX) else $error("data count not clamped");
  a_trail_ones: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == CIDFSK_TRAIL |=> fsk_bit.bit_value) else $error("trailing mark not one");
endmodule : cidfsk_regs

// ===== src/cidfsk_pkg.sv
// Package for the caller-ID FSK and line control register slice.
// Assumes a single 100 MHz clock domain and a command-byte register port.
package cidfsk_pkg;

  localparam int unsigned NCH = 4;

  // Register command codes: low seven bits address, top bit marks a write.
  localparam logic [6:0] ADDR_TX_SLOT   = 7'h00;
  localparam logic [6:0] ADDR_RX_SLOT   = 7'h01;
  localparam logic [6:0] ADDR_LOOP      = 7'h02;
  localparam logic [6:0] ADDR_FLAG_LEN  = 7'h32;
  localparam logic [6:0] ADDR_DATA_LEN  = 7'h33;
  localparam logic [6:0] ADDR_SEIZE_LEN = 7'h34;
  localparam logic [6:0] ADDR_MARK_LEN  = 7'h35;
  localparam logic [6:0] ADDR_FSK_CTRL  = 7'h36;
  localparam logic [6:0] ADDR_IRQ_POL   = 7'h37;
  localparam logic [6:0] ADDR_STATUS    = 7'h39;
  localparam int unsigned CMD_WRITE_BIT = 7;

  // Control register field positions.
  localparam int unsigned CTRL_GO     = 0;
  localparam int unsigned CTRL_TRAIL  = 1;
  localparam int unsigned CTRL_STD    = 2;
  localparam int unsigned CTRL_EN     = 3;
  localparam int unsigned CTRL_CS_LO  = 4;
  localparam int unsigned IRQPOL_BIT  = 4;
  localparam int unsigned HWY_BIT     = 7;

  // Loopback register field positions.
  localparam int unsigned LB_CUT   = 0;
  localparam int unsigned LB_APCM  = 1;
  localparam int unsigned LB_A2M   = 2;
  localparam int unsigned LB_A1M   = 3;
  localparam int unsigned LB_DPCM  = 5;
  localparam int unsigned LB_D2M   = 6;
  localparam logic [7:0]  LB_MASK  = 8'h6F;
  localparam logic [7:0]  CTRL_MASK = 8'h3F;
  localparam logic [7:0]  IRQPOL_MASK = 8'h10;

  localparam logic [7:0] DATA_MAX    = 8'h40;
  localparam logic [7:0] RESET_ZERO  = 8'h00;

  typedef enum logic [2:0] {
    CIDFSK_IDLE  = 3'b000,
    CIDFSK_SEIZE = 3'b001,
    CIDFSK_MARK  = 3'b011,
    CIDFSK_DATA  = 3'b010,
    CIDFSK_FLAG  = 3'b110,
    CIDFSK_TRAIL = 3'b111
  } cidfsk_state_e;

  typedef struct packed {
    logic       go;
    logic       trailing_mark_enable;
    logic       fsk_standard_select;
    logic       fsk_block_enable;
    logic [1:0] fsk_channel_select;
  } cidfsk_ctrl_s;

  typedef struct packed {
    logic       valid;
    logic       bit_value;
    logic       standard;
    logic [1:0] channel;
  } cidfsk_bit_s;

endpackage : cidfsk_pkg

// ===== src/cidfsk_fifo.sv
// Small flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module cidfsk_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cidfsk_fifo

// ===== tb/cidfsk_modem_model.sv
// Modulator model: gives bit ticks and records the FSK bit stream.
// Assumes the bench empties rx_q before each transmission.
`timescale 1ns/10ps
module cidfsk_modem_model
  import cidfsk_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Bit stream
  input  wire cidfsk_bit_s fsk_bit,
  output logic             bit_tick
);
  logic [3:0] gap;
  logic [3:0] cnt;
  logic [3:0] rx_q[$];

  initial begin
    bit_tick = 1'b0;
    gap      = 4'h3;
    cnt      = 4'h0;
  end

  // The bit period varies so that the sequencer must wait for every tick, prompt or slow.
  always @(posedge ref_clk) begin
    if (bit_tick && fsk_bit.valid) begin
      rx_q.push_back({fsk_bit.standard, fsk_bit.channel, fsk_bit.bit_value});
    end
    if (!resetn || cnt < gap) begin
      bit_tick <= 1'b0;
      cnt      <= resetn ? cnt + 4'h1 : 4'h0;
    end else begin
      bit_tick <= 1'b1;
      cnt      <= 4'h0;
      gap      <= 4'($urandom_range(6, 1));
    end
  end
endmodule : cidfsk_modem_model

// ===== tb/caller_id_fsk_and_line_control_regs_bench.sv
// Self-checking bench for the FSK sequencer and line control registers.
// Assumes the modem model supplies bit ticks and records the stream.
`timescale 1ns/10ps
module caller_id_fsk_and_line_control_regs_bench
  import cidfsk_pkg::*;
;
  logic             ref_clk;
  logic             resetn;
  logic             cmd_valid;
  logic [7:0]       cmd_byte;
  logic [7:0]       cmd_wdata;
  logic [NCH-1:0]   cmd_chan_mask;
  logic [1:0]       cmd_chan_sel;
  logic             rd_valid;
  logic [7:0]       rd_data;
  logic             circuit_control_port;
  logic [NCH-1:0]   offhook_flags;
  logic [NCH-1:0]   ground_key_flags;
  logic             hook_event;
  logic             irq_out;
  logic             cmd_channel_irq_a;
  logic             cmd_channel_irq_b;
  logic             msg_valid;
  logic             msg_ready;
  logic [7:0]       msg_data;
  cidfsk_bit_s      fsk_bit;
  logic             bit_tick;
  logic [NCH*8-1:0] tx_slot_out;
  logic [NCH*8-1:0] rx_slot_out;
  logic [NCH*8-1:0] loop_out;
  logic [7:0]       rdat;
  logic [7:0]       v;
  int               n_errors;
  int               num_checks;

  cidfsk_regs u_cidfsk_regs (.ref_clk, .resetn, .cmd_valid, .cmd_byte, .cmd_wdata,
    .cmd_chan_mask, .cmd_chan_sel, .rd_valid, .rd_data, .circuit_control_port,
    .offhook_flags, .ground_key_flags, .hook_event, .irq_out, .cmd_channel_irq_a,
    .cmd_channel_irq_b, .msg_valid, .msg_ready, .msg_data, .fsk_bit, .bit_tick,
    .tx_slot_out, .rx_slot_out, .loop_out);
  cidfsk_modem_model u_cidfsk_modem_model (.ref_clk, .resetn, .fsk_bit, .bit_tick);

  always #5 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic cmd(input logic wr, input logic [6:0] a, input logic [7:0] d,
                     input logic [3:0] m = 4'hF, input logic [1:0] s = 2'h0);
    @(posedge ref_clk);
    #1;
    cmd_valid     = 1'b1;
    cmd_byte      = {wr, a};
    cmd_wdata     = d;
    cmd_chan_mask = m;
    cmd_chan_sel  = s;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    rdat      = rd_data;
    if (!wr) check("rd_valid", rd_valid, 1'b1);
  endtask : cmd

  task automatic push(input logic [7:0] b);
    @(posedge ref_clk);
    #1;
    for (int i = 0; i < 2000 && msg_ready !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (msg_ready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    msg_valid = 1'b1;
    msg_data  = b;
    @(posedge ref_clk);
    #1;
    msg_valid = 1'b0;
  endtask : push

  task automatic wait_go();
    for (int i = 0; i < 5000; i++) begin
      cmd(1'b0, ADDR_FSK_CTRL, 8'h00);
      if (rdat[CTRL_GO] === 1'b0) return;
    end
    n_errors++;
    end_of_test();
  endtask : wait_go

  task automatic pulse_hook();
    @(posedge ref_clk);
    #1;
    hook_event = 1'b1;
    @(posedge ref_clk);
    #1;
    hook_event = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : pulse_hook

  function automatic logic [7:0] status_exp(input logic [3:0] hk, input logic [3:0] gk);
    for (int c = 0; c < 4; c++) begin
      status_exp[2*c]   = hk[c];
      status_exp[2*c+1] = gk[c];
    end
  endfunction : status_exp

  task automatic run(input int s, input int m, input int d, input int f,
                     input logic [1:0] cs, input logic bs, input logic tr);
    logic [7:0] q[$];
    logic [3:0] e[$];
    logic [3:0] got[$];
    int         n;
    n = (d > 64) ? 64 : d;
    for (int i = 0; i < n; i++) q.push_back(8'($urandom));
    for (int i = 0; i < 4 * s; i++) e.push_back({bs, cs, i[0]});
    for (int i = 0; i < m; i++) e.push_back({bs, cs, 1'b1});
    for (int b = 0; b < n; b++) begin
      for (int i = 0; i < f && b > 0; i++) e.push_back({bs, cs, 1'b1});
      for (int k = 0; k < 8; k++) e.push_back({bs, cs, q[b][k]});
    end
    cmd(1'b1, ADDR_FLAG_LEN, 8'(f));
    cmd(1'b1, ADDR_DATA_LEN, 8'(d));
    cmd(1'b1, ADDR_SEIZE_LEN, 8'(s));
    cmd(1'b1, ADDR_MARK_LEN, 8'(m));
    u_cidfsk_modem_model.rx_q.delete();
    while (q.size() > 0 && msg_ready === 1'b1) push(q.pop_front());
    if (n >= 8) check("fifo full", msg_ready, 1'b0);
    cmd(1'b1, ADDR_FSK_CTRL, {2'b00, cs, 1'b1, bs, tr, 1'b1});
    fork
      while (q.size() > 0) push(q.pop_front());
      wait_go();
    join
    if (tr) begin
      repeat (100) @(posedge ref_clk);
      cmd(1'b1, ADDR_FSK_CTRL, {2'b00, cs, 1'b1, bs, 2'b00});
    end
    repeat (40) @(posedge ref_clk);
    got = u_cidfsk_modem_model.rx_q;
    repeat (100) @(posedge ref_clk);
    check("silent", u_cidfsk_modem_model.rx_q.size(), got.size());
    for (int i = 0; i < got.size(); i++) begin
      check("bit", got[i], (i < e.size()) ? e[i] : {bs, cs, 1'b1});
    end
    check("bits", tr ? got.size() > e.size() : got.size() == e.size(), 1'b1);
  endtask : run

  initial begin
    {ref_clk, resetn, cmd_valid, cmd_byte, cmd_wdata, cmd_chan_mask, cmd_chan_sel} = '0;
    {circuit_control_port, offhook_flags, ground_key_flags, hook_event} = '0;
    {msg_valid, msg_data, n_errors, num_checks} = '0;
    void'($urandom(61590));
    repeat (5) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check("irq reset", irq_out, 1'b1);
    for (int c = 0; c < 4; c++) begin
      cmd(1'b0, ADDR_TX_SLOT, 8'h00, 4'h0, 2'(c));
      check("tx reset", rdat, 8'(c));
      check("tx out", tx_slot_out[8*c+:8], 8'(c));
      cmd(1'b0, ADDR_RX_SLOT, 8'h00, 4'h0, 2'(c));
      check("rx reset", rdat, 8'(c));
      cmd(1'b0, ADDR_LOOP, 8'h00, 4'h0, 2'(c));
      check("loop reset", rdat, 8'h00);
    end
    for (int a = 'h32; a < 'h39; a++) begin
      cmd(1'b0, 7'(a), 8'h00);
      check("reg reset", rdat, 8'h00);
    end
    cmd(1'b1, ADDR_FSK_CTRL, 8'h09);
    cmd(1'b0, ADDR_FSK_CTRL, 8'h00);
    check("go zero lengths", rdat, 8'h08);
    for (int c = 0; c < 4; c++) begin
      v = 8'($urandom);
      cmd(1'b1, ADDR_TX_SLOT, v, 4'(1 << c));
      cmd(1'b0, ADDR_TX_SLOT, 8'h00, 4'h0, 2'(c));
      check("tx slot", rdat, v);
      check("tx out", tx_slot_out[8*c+:8], v);
      cmd(1'b1, ADDR_RX_SLOT, ~v, 4'(1 << c));
      @(posedge ref_clk);
      #1;
      check("rx out", rx_slot_out[8*c+:8], 8'(~v));
    end
    circuit_control_port = 1'b1;
    cmd(1'b1, ADDR_TX_SLOT, 8'h00);
    cmd(1'b1, ADDR_LOOP, 8'hFF);
    cmd(1'b0, ADDR_TX_SLOT, 8'h00, 4'h0, 2'h3);
    check("circuit slot", rdat, v);
    check("circuit loop", loop_out[7:0], LB_MASK & ~8'h22);
    cmd(1'b0, ADDR_STATUS, 8'h00);
    check("circuit status", rdat, 8'h00);
    circuit_control_port = 1'b0;
    cmd(1'b1, ADDR_LOOP, 8'hFF);
    @(posedge ref_clk);
    #1;
    check("loop out", loop_out, {4{LB_MASK}});
    cmd(1'b1, ADDR_LOOP, 8'h00);
    offhook_flags    = 4'($urandom);
    ground_key_flags = 4'($urandom);
    cmd(1'b0, ADDR_STATUS, 8'h00);
    check("status", rdat, status_exp(offhook_flags, ground_key_flags));
    pulse_hook();
    check("irq low", irq_out, 1'b0);
    check("irq chan", cmd_channel_irq_a, 1'b0);
    cmd(1'b0, ADDR_STATUS, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    check("read clear", irq_out, 1'b1);
    pulse_hook();
    check("irq again", irq_out, 1'b0);
    cmd(1'b1, ADDR_STATUS, 8'($urandom));
    repeat (2) @(posedge ref_clk);
    #1;
    check("write clear", irq_out, 1'b1);
    cmd(1'b1, ADDR_IRQ_POL, 8'hFF);
    cmd(1'b0, ADDR_IRQ_POL, 8'h00);
    check("polarity", rdat, IRQPOL_MASK);
    check("irq idle", irq_out, 1'b0);
    pulse_hook();
    check("irq high", cmd_channel_irq_b, 1'b1);
    cmd(1'b1, ADDR_STATUS, 8'h00);
    cmd(1'b1, ADDR_IRQ_POL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      run($urandom_range(3, 1), $urandom_range(6), $urandom_range(10, 1), $urandom_range(3),
          2'(c), c[0], c == 2);
    end
    run(1, 2, 70, 1, 2'h3, 1'b1, 1'b0);
    run(0, 3, 0, 2, 2'h1, 1'b0, 1'b0);
    u_cidfsk_modem_model.rx_q.delete();
    cmd(1'b1, ADDR_FSK_CTRL, 8'h01);
    repeat (200) @(posedge ref_clk);
    check("disabled", u_cidfsk_modem_model.rx_q.size(), 0);
    end_of_test();
  end
endmodule : caller_id_fsk_and_line_control_regs_bench
